// [rtl/awc_chan.sv]
// One channel: hysteresis window classification with held code
`timescale 1ns/1ps
module awc_chan
   import awc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [AWC_CODE_W-1:0] code,
   input wire logic [15:0] low_thr,
   input wire logic [15:0] mid_thr,
   input wire logic [15:0] high_thr,
   input wire logic [15:0] hyst,
   output logic signal_bit,
   output logic fault_bit
);
   logic [17:0] c;
   logic [17:0] l_lo;
   logic [17:0] l_hi;
   logic [17:0] m_lo;
   logic [17:0] m_hi;
   logic [17:0] h_lo;
   logic [17:0] h_hi;
   logic [1:0] state_r;
   logic [1:0] state_nxt;

   // Signed 18-bit math so threshold minus margin cannot wrap below zero
   assign c = {6'h00, code};
   assign l_lo = {2'b00, low_thr} - {2'b00, hyst};
   assign l_hi = {2'b00, low_thr} + {2'b00, hyst};
   assign m_lo = {2'b00, mid_thr} - {2'b00, hyst};
   assign m_hi = {2'b00, mid_thr} + {2'b00, hyst};
   assign h_lo = {2'b00, high_thr} - {2'b00, hyst};
   assign h_hi = {2'b00, high_thr} + {2'b00, hyst};

   always_comb begin
      state_nxt = state_r;
      if ($signed(c) < $signed(l_lo)) begin
         state_nxt = 2'b10;
      end else if ($signed(c) > $signed(h_hi)) begin
         state_nxt = 2'b11;
      end else if ($signed(c) > $signed(l_hi) && $signed(c) < $signed(m_lo)) begin
         state_nxt = 2'b00;
      end else if ($signed(c) > $signed(m_hi) && $signed(c) < $signed(h_lo)) begin
         state_nxt = 2'b01;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= 2'b00;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign fault_bit = state_r[1];
   assign signal_bit = state_r[0];
endmodule

// [rtl/awc_pkg.sv]
// Package: register offsets, widths and reset values of the window comparator
package awc_pkg;
   localparam int AWC_CH_NUM = 8;
   localparam int AWC_CODE_W = 12;
   localparam int AWC_REG_W = 16;
   localparam logic [9:0] AWC_ADDR_SUMMARY = 10'h1f4;
   localparam logic [9:0] AWC_ADDR_LOW = 10'h1f5;
   localparam logic [9:0] AWC_ADDR_MID = 10'h1f6;
   localparam logic [9:0] AWC_ADDR_HIGH = 10'h1f7;
   localparam logic [9:0] AWC_ADDR_HYST = 10'h1f8;
   localparam logic [9:0] AWC_ADDR_AREF = 10'h10e;
   localparam logic [15:0] AWC_HYST_MAX = 16'h001d;
   localparam logic [15:0] AWC_HYST_BAD_WORD = 16'hff00;
   localparam logic [15:0] AWC_RST_LOW = 16'h0000;
   localparam logic [15:0] AWC_RST_MID = 16'h0000;
   localparam logic [15:0] AWC_RST_HIGH = 16'h0000;
   localparam logic [15:0] AWC_RST_HYST = 16'h0000;
   localparam logic [15:0] AWC_RST_AREF = 16'h0000;
   localparam int AWC_FAULT_OFS = 8;
endpackage

// [rtl/awc_top.sv]
// Top: analog window comparator with its holding registers
`timescale 1ns/1ps
// How it works
// - Compare each channel code against three thresholds
// - One shared hysteresis register, symmetric margin
// - Two-bit code per channel from four bands
// - Fault bit outside low-to-high normal band
// - Signal bit set above middle threshold
// - Signals in low byte, faults high byte
// - Hysteresis above 29 reads summary as ff00
// - Reference setting zero selects five volt supply
// - All registers readable as holding registers
module awc_top
   import awc_pkg::*;
#(
   parameter int CH_NUM = AWC_CH_NUM
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [CH_NUM*AWC_CODE_W-1:0] ch_codes,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [9:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   output logic reg_err,
   output logic use_supply_ref,
   output logic [15:0] aref_setting
);
   logic rst_s1_r;
   logic rst_n_r;
   logic [15:0] low_r;
   logic [15:0] mid_r;
   logic [15:0] high_r;
   logic [15:0] hyst_r;
   logic [15:0] aref_r;
   logic [CH_NUM-1:0] sig_w;
   logic [CH_NUM-1:0] flt_w;
   logic [15:0] summary;
   logic [15:0] rdata_r;
   logic ack_r;
   logic err_r;
   logic hit;

   logic [15:0] packed_word;
   logic margin_bad;
   logic [15:0] rd_word;
   logic sel_summary;
   logic sel_low;
   logic sel_mid;
   logic sel_high;
   logic sel_hyst;
   logic sel_aref;
   logic wr_low;
   logic wr_mid;
   logic wr_high;
   logic wr_hyst;
   logic wr_aref;
   logic bad_rd;
   logic bad_wr;
   logic ref_is_zero;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // Codes come from the converter on this clock, so no synchroniser
   genvar g;
   generate
      for (g = 0; g < CH_NUM; g++) begin : g_ch
         awc_chan u_chan (
            .mclk(mclk),
            .rst_n(rst_n_r),
            .code(ch_codes[g*AWC_CODE_W +: AWC_CODE_W]),
            .low_thr(low_r),
            .mid_thr(mid_r),
            .high_thr(high_r),
            .hyst(hyst_r),
            .signal_bit(sig_w[g]),
            .fault_bit(flt_w[g])
         );
      end
   endgenerate

   // Pack: signal bits low byte, fault bits high byte
   always_comb begin
      packed_word = 16'h0000;
      packed_word[CH_NUM-1:0] = sig_w;
      packed_word[AWC_FAULT_OFS +: CH_NUM] = flt_w;
   end

   // An illegal margin makes every band unreliable
   assign margin_bad = (hyst_r > AWC_HYST_MAX);

   always_comb begin
      summary = packed_word;
      if (margin_bad) begin
         summary = AWC_HYST_BAD_WORD;
      end
   end

   assign sel_summary = (reg_addr == AWC_ADDR_SUMMARY);
   assign sel_low = (reg_addr == AWC_ADDR_LOW);
   assign sel_mid = (reg_addr == AWC_ADDR_MID);
   assign sel_high = (reg_addr == AWC_ADDR_HIGH);
   assign sel_hyst = (reg_addr == AWC_ADDR_HYST);
   assign sel_aref = (reg_addr == AWC_ADDR_AREF);

   always_comb begin
      hit = 1'b1;
      unique case (reg_addr)
         AWC_ADDR_SUMMARY, AWC_ADDR_LOW, AWC_ADDR_MID: hit = 1'b1;
         AWC_ADDR_HIGH, AWC_ADDR_HYST, AWC_ADDR_AREF: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // Summary is read-only; writes to it are answered with an error
   assign wr_low = reg_wr & sel_low;
   assign wr_mid = reg_wr & sel_mid;
   assign wr_high = reg_wr & sel_high;
   assign wr_hyst = reg_wr & sel_hyst;
   assign wr_aref = reg_wr & sel_aref;
   assign bad_rd = reg_rd & ~hit;
   assign bad_wr = reg_wr & (~hit | sel_summary);

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         low_r <= AWC_RST_LOW;
      end else if (wr_low) begin
         low_r <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mid_r <= AWC_RST_MID;
      end else if (wr_mid) begin
         mid_r <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         high_r <= AWC_RST_HIGH;
      end else if (wr_high) begin
         high_r <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         hyst_r <= AWC_RST_HYST;
      end else if (wr_hyst) begin
         hyst_r <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         aref_r <= AWC_RST_AREF;
      end else if (wr_aref) begin
         aref_r <= reg_wdata;
      end
   end

   // Unmapped reads return zero beside the error
   always_comb begin
      rd_word = 16'h0000;
      if (sel_summary) begin
         rd_word = summary;
      end else if (sel_low) begin
         rd_word = low_r;
      end else if (sel_mid) begin
         rd_word = mid_r;
      end else if (sel_high) begin
         rd_word = high_r;
      end else if (sel_hyst) begin
         rd_word = hyst_r;
      end else if (sel_aref) begin
         rd_word = aref_r;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= reg_rd | reg_wr;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         err_r <= 1'b0;
      end else begin
         err_r <= bad_rd | bad_wr;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata_r <= 16'h0000;
      end else if (reg_rd) begin
         rdata_r <= rd_word;
      end
   end

   // Zero selects the board supply as reference
   assign ref_is_zero = (aref_r == 16'h0000);
   assign reg_rdata = rdata_r;
   assign reg_ack = ack_r;
   assign reg_err = err_r;
   assign aref_setting = aref_r;
   assign use_supply_ref = ref_is_zero;
endmodule

// [tb/awc_lines.sv]
// Sensor line model: converted line levels
`timescale 1ns/1ps
module awc_lines
   import awc_pkg::*;
(
   input wire logic mclk,
   input wire logic [AWC_CH_NUM*AWC_CODE_W-1:0] level,
   output logic [AWC_CH_NUM*AWC_CODE_W-1:0] ch_codes
);
   // Conversion lags the line by one sample
   always_ff @(posedge mclk) ch_codes <= level;
endmodule

// [tb/awc_properties.sv]
// Checker: bus and status relations of the comparator
`timescale 1ns/1ps
module awc_checker
   import awc_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [9:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_err,
   input wire logic use_supply_ref,
   input wire logic [15:0] aref_setting
);
   logic [15:0] hyst_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Shadow of the margin, to know when summary must read bad
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) hyst_r <= 16'h0000;
      else if (reg_wr && reg_addr == AWC_ADDR_HYST) hyst_r <= reg_wdata;
   end
   AST_ACK: assert property (reg_rd || reg_wr |=> reg_ack) else $error("no ack");
   AST_ERR_ACK: assert property (reg_err |-> reg_ack) else $error("lone err");
   AST_SUM_WR: assert property (reg_wr && reg_addr == AWC_ADDR_SUMMARY |=> reg_err)
      else $error("summary write taken");
   AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
   AST_UNMAP: assert property (reg_rd && reg_addr > AWC_ADDR_HYST |=> reg_err)
      else $error("unmapped read");
   AST_REF: assert property (use_supply_ref == (aref_setting == 16'h0000))
      else $error("ref select");
   AST_REF_WR: assert property (reg_wr && reg_addr == AWC_ADDR_AREF
      |=> aref_setting == $past(reg_wdata)) else $error("ref write");
   AST_HYST_BAD: assert property (reg_rd && reg_addr == AWC_ADDR_SUMMARY
      && hyst_r > AWC_HYST_MAX |=> reg_rdata == AWC_HYST_BAD_WORD) else $error("bad margin");
   cover property (reg_rd && reg_addr == AWC_ADDR_SUMMARY);
   cover property (reg_err);
   cover property (!use_supply_ref);
endmodule

// [tb/tb.sv]
// Testbench: register and status tests
`timescale 1ns/1ps
module tb import awc_pkg::*;;
   logic mclk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic reg_ack, reg_err, use_supply_ref;
   logic [9:0] reg_addr = 10'h000;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, aref_setting;
   logic [95:0] level = 96'h0, ch_codes;
   int n_mismatch = 0, n_compared = 0;
   always #5 mclk = ~mclk;
   awc_lines u_awc_lines (.mclk(mclk), .level(level), .ch_codes(ch_codes));
   awc_top u_awc_top (.mclk(mclk), .arst_n(arst_n), .ch_codes(ch_codes), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_err(reg_err), .use_supply_ref(use_supply_ref),
      .aref_setting(aref_setting));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d);
      @(posedge mclk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge mclk);
      {reg_wr, reg_rd} <= 2'h0;
      #1;
      chk({15'h0000, reg_ack}, 16'h0001, "ack");
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      acc(1'b0, AWC_ADDR_LOW, 16'h0000);
      chk(reg_rdata, AWC_RST_LOW, "low reset");
      chk({15'h0000, use_supply_ref}, 16'h0001, "supply ref");
      acc(1'b0, AWC_ADDR_SUMMARY, 16'h0000);
      chk(reg_rdata, 16'h0000, "summary reset");
      acc(1'b1, AWC_ADDR_AREF, 16'h0005);
      chk({15'h0000, use_supply_ref}, 16'h0000, "supply ref");
      chk(aref_setting, 16'h0005, "aref setting");
      acc(1'b0, AWC_ADDR_AREF, 16'h0000);
      chk(reg_rdata, 16'h0005, "aref readback");
      acc(1'b1, AWC_ADDR_SUMMARY, 16'h1234);
      chk({15'h0000, reg_err}, 16'h0001, "summary write");
      acc(1'b1, 10'h3ff, 16'h0000);
      chk({15'h0000, reg_err}, 16'h0001, "unmapped write");
      acc(1'b0, 10'h3ff, 16'h0000);
      chk({reg_err, reg_rdata[14:0]}, 16'h8000, "unmapped");
      $display("test bus done");
      // Thresholds 1000/2000/3000, margin 10
      acc(1'b1, AWC_ADDR_LOW, 16'h03e8);
      acc(1'b1, AWC_ADDR_MID, 16'h07d0);
      acc(1'b1, AWC_ADDR_HIGH, 16'h0bb8);
      acc(1'b1, AWC_ADDR_HYST, 16'h000a);
      acc(1'b0, AWC_ADDR_MID, 16'h0000);
      chk(reg_rdata, 16'h07d0, "mid readback");
      acc(1'b0, AWC_ADDR_HIGH, 16'h0000);
      chk(reg_rdata, 16'h0bb8, "high readback");
      acc(1'b0, AWC_ADDR_HYST, 16'h0000);
      chk(reg_rdata, 16'h000a, "margin readback");
      level <= {{4{12'h5dc}}, 12'hdac, 12'h9c4, 12'h5dc, 12'h1f4};
      acc(1'b0, AWC_ADDR_SUMMARY, 16'h0000);
      acc(1'b0, AWC_ADDR_SUMMARY, 16'h0000);
      chk(reg_rdata, 16'h090c, "summary");
      // Both codes cross the middle threshold inside the margin, so they hold
      level <= {{4{12'h5dc}}, 12'hdac, 12'h7cb, 12'h7d5, 12'h1f4};
      acc(1'b0, AWC_ADDR_SUMMARY, 16'h0000);
      acc(1'b0, AWC_ADDR_SUMMARY, 16'h0000);
      chk(reg_rdata, 16'h090c, "held");
      acc(1'b1, AWC_ADDR_HYST, 16'h001e);
      acc(1'b0, AWC_ADDR_SUMMARY, 16'h0000);
      chk(reg_rdata, AWC_HYST_BAD_WORD, "margin 30");
      acc(1'b1, AWC_ADDR_HYST, AWC_HYST_MAX);
      acc(1'b0, AWC_ADDR_SUMMARY, 16'h0000);
      chk(reg_rdata, 16'h090c, "margin 29");
      $display("test status done");
      end_of_test();
   end
   initial begin
      repeat (500) @(posedge mclk);
      n_mismatch++;
      end_of_test();
   end
endmodule
bind awc_top awc_checker u_awc_checker (.mclk(mclk), .arst_n(arst_n), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_ack(reg_ack), .reg_err(reg_err), .use_supply_ref(use_supply_ref),
   .aref_setting(aref_setting));
